// file: rtl/ioe_defines.vh
// Constants shared by the indexed offset instruction executor.
`ifndef IOE_DEFINES_VH
`define IOE_DEFINES_VH

// Register byte offsets on the APB.
`define IOE_OFS_CTRL     8'h00
`define IOE_OFS_INSTR    8'h04
`define IOE_OFS_WREG     8'h08
`define IOE_OFS_FP       8'h0c
`define IOE_OFS_STATUS   8'h10
`define IOE_OFS_BSR      8'h14
`define IOE_OFS_MADDR    8'h18
`define IOE_OFS_MDATA    8'h1c
`define IOE_OFS_EADDR    8'h20

// Reset values.
`define IOE_RST_CTRL     1'b0
`define IOE_RST_BYTE     8'h00
`define IOE_RST_ADDR     12'h000
`define IOE_RST_BSR      4'h0
`define IOE_RST_FLAGS    5'h00
`define IOE_RST_INSTR    16'h0000

// Field positions.
`define IOE_CTRL_EXT_BIT 0
`define IOE_ST_C         0
`define IOE_ST_DC        1
`define IOE_ST_Z         2
`define IOE_ST_OV        3
`define IOE_ST_N         4
`define IOE_ST_BUSY      8
`define IOE_ST_INDEXED   9
`define IOE_ST_ILLEGAL   10

// Opcode patterns and operand limits.
`define IOE_OPC_ADD      6'b001001
`define IOE_OPC_BSF      4'b1000
`define IOE_OPC_SET_ALL_INDEXED     7'b0110100
`define IOE_OFFSET_MAX   8'h5f
`define IOE_ACCESS_HIGH  4'hf
`define IOE_ALL_ONES     8'hff

// Instruction classes.
`define IOE_CLS_NONE     2'd0
`define IOE_CLS_ADD      2'd1
`define IOE_CLS_BSF      2'd2
`define IOE_CLS_SET_ALL_INDEXED     2'd3

// One instruction cycle is four phases on the core clock.
`define IOE_PHASES       4
`define IOE_PHASE_LAST   2'd3

`endif

// file: rtl/ioe_qphase.v
// Four-phase instruction cycle sequencer.
`timescale 1ns/1ps
`include "ioe_defines.vh"

module ioe_qphase (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       start,
    output reg        busy_reg,
    output wire [3:0] q_phase
);

    reg [1:0] phase_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg  <= 1'b0;
            phase_reg <= 2'd0;
        end else if (!busy_reg) begin
            if (start) begin
                busy_reg  <= 1'b1;
                phase_reg <= 2'd0;
            end
        end else if (phase_reg == `IOE_PHASE_LAST) begin
            busy_reg  <= 1'b0;
            phase_reg <= 2'd0;
        end else begin
            phase_reg <= phase_reg + 2'd1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `IOE_PHASES; i = i + 1) begin : g_phase
            localparam [1:0] PH_CODE = i;
            assign q_phase[i] = busy_reg && (phase_reg == PH_CODE);
        end
    endgenerate

endmodule

// file: rtl/ioe_exec.v
// Executor for byte and bit instructions in indexed literal offset mode, with APB access.
`timescale 1ns/1ps
`include "ioe_defines.vh"

// Functional notes
// [RULE_01] Extended set on: access-bank operand at or below 5Fh is frame pointer offset.
// [RULE_02] Offset mode only when access select bit is 0 and extended set is on.
// [RULE_03] Add form 0010 01d0 plus offset k in 0..95; d picks destination.
// [RULE_04] Add sums working register and indexed byte; d=0 to working, d=1 to memory.
// [RULE_05] Add updates negative, overflow, carry, digit carry and zero flags.
// [RULE_06] Form 1000 bbb0 sets bit b of indexed byte; flags unchanged.
// [RULE_07] Form 0110 1000 writes FFh to indexed byte; flags unchanged.
// [RULE_08] One word, one cycle: decode, read, process, write phases.
// [RULE_09] Extended set enable resets to 0; software must set it first.
// [RULE_10] Above 5Fh or access select 1 keeps standard literal or banked addressing.
// [RULE_11] Indexed address is frame pointer plus zero-extended offset; pointer unchanged.
module ioe_exec (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_reg,
    output reg         pready_reg,
    output reg         pslverr_reg,
    output wire        exec_busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    function [1:0] ioe_class;
        input [15:0] word;
        begin
            if (word[15:10] == `IOE_OPC_ADD)
                ioe_class = `IOE_CLS_ADD;
            else if (word[15:12] == `IOE_OPC_BSF)
                ioe_class = `IOE_CLS_BSF;
            else if (word[15:9] == `IOE_OPC_SET_ALL_INDEXED)
                ioe_class = `IOE_CLS_SET_ALL_INDEXED;
            else
                ioe_class = `IOE_CLS_NONE;
        end
    endfunction

    // Returns {indexed, address}.
    function [12:0] ioe_ea;
        input [7:0]  f;
        input        a;
        input        ext;
        input [11:0] fp;
        input [3:0]  bsr;
        begin
            if (ext && !a && (f <= `IOE_OFFSET_MAX))
                ioe_ea = {1'b1, fp + {4'h0, f}};                  // [RULE_01] [RULE_02] [RULE_11]
            else if (a)
                ioe_ea = {1'b0, bsr, f};                          // [RULE_10]
            else if (f <= `IOE_OFFSET_MAX)
                ioe_ea = {1'b0, 4'h0, f};                         // [RULE_10]
            else
                ioe_ea = {1'b0, `IOE_ACCESS_HIGH, f};             // [RULE_10]
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    reg  [7:0]  mem [0:4095];

    reg         ext_en_reg;
    reg  [15:0] instr_reg;
    reg  [7:0]  wreg_reg;
    reg  [11:0] fp_reg;
    reg  [4:0]  flags_reg;
    reg  [3:0]  bsr_reg;
    reg  [11:0] maddr_reg;
    reg  [11:0] ea_reg;
    reg         indexed_reg;
    reg         illegal_reg;
    reg  [1:0]  cls_reg;
    reg  [7:0]  opnd_reg;
    reg  [7:0]  result_reg;
    reg  [4:0]  flags_next_reg;

    wire [3:0]  q_phase;
    wire        busy;
    wire [12:0] ea_dec;
    wire [8:0]  sum;
    wire [4:0]  low_sum;

    reg  [31:0] prdata_next;
    reg         pslverr_next;
    reg         mem_we;
    reg  [11:0] mem_wa;
    reg  [7:0]  mem_wd;

    wire access_done = psel && penable && pready_reg;
    wire wr_fire     = access_done && pwrite && !pslverr_reg;
    wire start       = wr_fire && (paddr == `IOE_OFS_INSTR);

    assign exec_busy = busy;

    ioe_qphase u_qphase (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start),
        .busy_reg(busy),
        .q_phase (q_phase)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave. Zero wait states: the answer is prepared in the setup cycle.

    always @* begin
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        case (paddr)
            `IOE_OFS_CTRL:   prdata_next = {31'h0000_0000, ext_en_reg};
            `IOE_OFS_INSTR:  prdata_next = {14'h0000, ioe_class(instr_reg), instr_reg};
            `IOE_OFS_WREG:   prdata_next = {24'h00_0000, wreg_reg};
            `IOE_OFS_FP:     prdata_next = {20'h0_0000, fp_reg};
            `IOE_OFS_STATUS: prdata_next = {21'h00_0000, illegal_reg, indexed_reg,
                                            busy, 3'h0, flags_reg};
            `IOE_OFS_BSR:    prdata_next = {28'h000_0000, bsr_reg};
            `IOE_OFS_MADDR:  prdata_next = {20'h0_0000, maddr_reg};
            `IOE_OFS_MDATA:  prdata_next = {24'h00_0000, mem[maddr_reg]};
            `IOE_OFS_EADDR:  prdata_next = {20'h0_0000, ea_reg};
            default:         pslverr_next = 1'b1;
        endcase
        // Writes during an instruction cycle would race the executor, so they are refused.
        if (pwrite && busy)
            pslverr_next = 1'b1;
        if (pwrite && (paddr == `IOE_OFS_EADDR))
            pslverr_next = 1'b1;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= psel && !penable;
            if (psel && !penable) begin
                prdata_reg  <= pwrite ? 32'h0000_0000 : prdata_next;
                pslverr_reg <= pslverr_next;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction cycle.

    assign ea_dec  = ioe_ea(instr_reg[7:0], instr_reg[8], ext_en_reg, fp_reg, bsr_reg);
    assign sum     = {1'b0, wreg_reg} + {1'b0, opnd_reg};
    assign low_sum = {1'b0, wreg_reg[3:0]} + {1'b0, opnd_reg[3:0]};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cls_reg        <= `IOE_CLS_NONE;
            ea_reg         <= `IOE_RST_ADDR;
            indexed_reg    <= 1'b0;
            illegal_reg    <= 1'b0;
            opnd_reg       <= `IOE_RST_BYTE;
            result_reg     <= `IOE_RST_BYTE;
            flags_next_reg <= `IOE_RST_FLAGS;
        end else begin
            if (q_phase[0]) begin
                cls_reg     <= ioe_class(instr_reg);              // [RULE_03] [RULE_06] [RULE_07] [RULE_08]
                ea_reg      <= ea_dec[11:0];
                indexed_reg <= ea_dec[12];
                illegal_reg <= (ioe_class(instr_reg) == `IOE_CLS_NONE);
            end
            if (q_phase[1])
                opnd_reg <= mem[ea_reg];                          // [RULE_08]
            if (q_phase[2]) begin
                flags_next_reg <= flags_reg;
                case (cls_reg)
                    `IOE_CLS_ADD: begin
                        result_reg <= sum[7:0];                   // [RULE_04]
                        flags_next_reg[`IOE_ST_C]  <= sum[8];     // [RULE_05]
                        flags_next_reg[`IOE_ST_DC] <= low_sum[4];
                        flags_next_reg[`IOE_ST_Z]  <= (sum[7:0] == 8'h00);
                        flags_next_reg[`IOE_ST_N]  <= sum[7];
                        flags_next_reg[`IOE_ST_OV] <= (wreg_reg[7] == opnd_reg[7]) &&
                                                      (sum[7] != wreg_reg[7]);
                    end
                    `IOE_CLS_BSF:  result_reg <= opnd_reg | (8'h01 << instr_reg[11:9]); // [RULE_06]
                    `IOE_CLS_SET_ALL_INDEXED: result_reg <= `IOE_ALL_ONES;   // [RULE_07]
                    default:       result_reg <= opnd_reg;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software-visible registers; the executor writes them only in the last phase.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_en_reg <= `IOE_RST_CTRL;                          // [RULE_09]
            instr_reg  <= `IOE_RST_INSTR;
            wreg_reg   <= `IOE_RST_BYTE;
            fp_reg     <= `IOE_RST_ADDR;
            flags_reg  <= `IOE_RST_FLAGS;
            bsr_reg    <= `IOE_RST_BSR;
            maddr_reg  <= `IOE_RST_ADDR;
        end else if (q_phase[3]) begin
            if (cls_reg == `IOE_CLS_ADD) begin
                flags_reg <= flags_next_reg;                      // [RULE_05]
                if (!instr_reg[9])
                    wreg_reg <= result_reg;                       // [RULE_04]
            end
        end else if (wr_fire) begin
            case (paddr)
                `IOE_OFS_CTRL:   ext_en_reg <= pwdata[`IOE_CTRL_EXT_BIT];
                `IOE_OFS_INSTR:  instr_reg  <= pwdata[15:0];
                `IOE_OFS_WREG:   wreg_reg   <= pwdata[7:0];
                `IOE_OFS_FP:     fp_reg     <= pwdata[11:0];
                `IOE_OFS_STATUS: flags_reg  <= pwdata[4:0];
                `IOE_OFS_BSR:    bsr_reg    <= pwdata[3:0];
                `IOE_OFS_MADDR:  maddr_reg  <= pwdata[11:0];
                default:         ext_en_reg <= ext_en_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory. Software writes are refused while busy, so the ports never collide.

    always @* begin
        mem_we = 1'b0;
        mem_wa = maddr_reg;
        mem_wd = pwdata[7:0];
        if (q_phase[3]) begin
            mem_wa = ea_reg;
            mem_wd = result_reg;
            case (cls_reg)
                `IOE_CLS_ADD:  mem_we = instr_reg[9];             // [RULE_04]
                `IOE_CLS_BSF:  mem_we = 1'b1;                     // [RULE_06] [RULE_08]
                `IOE_CLS_SET_ALL_INDEXED: mem_we = 1'b1;                     // [RULE_07] [RULE_08]
                default:       mem_we = 1'b0;
            endcase
        end else if (wr_fire && (paddr == `IOE_OFS_MDATA)) begin
            mem_we = 1'b1;
        end
    end

    always @(posedge pclk) begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

endmodule

// file: sim/ioe_exec_properties.sv
// Concurrent checks on the APB and execution ports of the indexed executor.
`timescale 1ns/1ps
`include "ioe_defines.vh"
module ioe_exec_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata_reg,
    input wire logic        pready_reg,
    input wire logic        pslverr_reg,
    input wire logic        exec_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic setup_c = psel && !penable;
    wire logic unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h20);
    wire logic instr_ok = psel && penable && pwrite && pready_reg && !pslverr_reg
                          && (paddr == `IOE_OFS_INSTR);
    ////////////////////////////////////////////////////////////////////////////
    answer_next_a: assert property (setup_c |=> pready_reg)
        else $error("no answer after setup");
    answer_only_a: assert property (pready_reg |-> $past(setup_c))
        else $error("ready without setup");
    err_ready_a: assert property (pslverr_reg |-> pready_reg)
        else $error("error outside access cycle");
    unmapped_err_a: assert property (pready_reg && unmapped |-> pslverr_reg && prdata_reg == 0)
        else $error("unmapped access not refused");
    eaddr_ro_a: assert property (pready_reg && pwrite && paddr == `IOE_OFS_EADDR |-> pslverr_reg)
        else $error("write to effective address accepted");
    busy_refuse_a: assert property (setup_c && pwrite && exec_busy |=> pslverr_reg)
        else $error("write during execution accepted");
    four_phase_a: assert property (instr_ok |=> exec_busy [*4] ##1 !exec_busy)
        else $error("execution not four phases");
    busy_cause_a: assert property ($rose(exec_busy) |-> $past(instr_ok))
        else $error("execution without instruction write");
endmodule

// file: sim/tb_top.sv
// Directed testbench for the indexed offset instruction executor.
`timescale 1ns/1ps
`include "ioe_defines.vh"
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        exec_busy;
    logic [31:0] rdat;
    logic        rerr;
    int          fail_count = 0;
    int          check_count = 0;
    logic [15:0] mode_word [4] = '{16'h6860, 16'h6920, 16'h682c, 16'h685f};
    logic [11:0] mode_addr [4] = '{12'hf60, 12'h320, 12'h02c, 12'ha5f};

    always #2 pclk = ~pclk;

    ioe_exec uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg),
        .pready_reg(pready_reg), .pslverr_reg(pslverr_reg), .exec_busy(exec_busy));
    ////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Requests are held until pready is sampled high, then released for one idle cycle.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_reg !== 1'b1 && n < 16);
        if (n >= 16) fail_count++;
        rdat = prdata_reg;
        rerr = pslverr_reg;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        chk({31'h0, rerr}, 32'h0);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task mem_wr(input logic [11:0] a, input logic [7:0] d);
        wr(`IOE_OFS_MADDR, {20'h0, a});
        wr(`IOE_OFS_MDATA, {24'h0, d});
    endtask
    task mem_chk(input logic [11:0] a, input logic [7:0] exp);
        wr(`IOE_OFS_MADDR, {20'h0, a});
        rd_chk(`IOE_OFS_MDATA, {24'h0, exp});
    endtask
    task wait_idle;
        int n;
        n = 0;
        while (exec_busy !== 1'b0 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 16) fail_count++;
    endtask
    task run(input logic [15:0] w);
        wr(`IOE_OFS_INSTR, {16'h0, w});
        wait_idle();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd_chk(`IOE_OFS_CTRL, 32'h0);
        rd_chk(`IOE_OFS_STATUS, 32'h0);
        rd_chk(`IOE_OFS_WREG, 32'h0);
    endtask
    task t_add;
        wr(`IOE_OFS_CTRL, 32'h1);
        wr(`IOE_OFS_FP, 32'ha00);
        wr(`IOE_OFS_WREG, 32'h17);
        mem_wr(12'ha2c, 8'h20);
        run(16'h242c);
        rd_chk(`IOE_OFS_WREG, 32'h37);
        mem_chk(12'ha2c, 8'h20);
        rd_chk(`IOE_OFS_EADDR, 32'ha2c);
        rd_chk(`IOE_OFS_FP, 32'ha00);
        rd_chk(`IOE_OFS_STATUS, 32'h200);
        rd_chk(`IOE_OFS_INSTR, 32'h1242c);
        // Pointer near the top of memory checks the offset wrap and the d=1 path.
        wr(`IOE_OFS_FP, 32'hfe0);
        wr(`IOE_OFS_WREG, 32'h80);
        mem_wr(12'h03f, 8'h80);
        run(16'h265f);
        mem_chk(12'h03f, 8'h00);
        rd_chk(`IOE_OFS_WREG, 32'h80);
        rd_chk(`IOE_OFS_STATUS, 32'h20d);
        rd_chk(`IOE_OFS_EADDR, 32'h03f);
        wr(`IOE_OFS_FP, 32'ha00);
        wr(`IOE_OFS_WREG, 32'h7f);
        mem_wr(12'ha00, 8'h01);
        run(16'h2400);
        rd_chk(`IOE_OFS_WREG, 32'h80);
        rd_chk(`IOE_OFS_STATUS, 32'h21a);
    endtask
    task t_bits;
        int e;
        wr(`IOE_OFS_STATUS, 32'h1f);
        mem_wr(12'ha0a, 8'h00);
        for (int b = 0; b < 8; b++) begin
            run({4'h8, b[2:0], 9'h00a});
            e = (2 << b) - 1;
            mem_chk(12'ha0a, e[7:0]);
        end
        rd_chk(`IOE_OFS_STATUS, 32'h21f);
        mem_wr(12'ha2c, 8'h00);
        run(16'h682c);
        mem_chk(12'ha2c, 8'hff);
        rd_chk(`IOE_OFS_STATUS, 32'h21f);
        rd_chk(`IOE_OFS_INSTR, 32'h3682c);
    endtask
    task t_modes;
        wr(`IOE_OFS_BSR, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(`IOE_OFS_CTRL, {31'h0, i != 2});
            mem_wr(mode_addr[i], 8'h00);
            run(mode_word[i]);
            rd_chk(`IOE_OFS_EADDR, {20'h0, mode_addr[i]});
            mem_chk(mode_addr[i], 8'hff);
        end
    endtask
    task t_busy;
        wr(`IOE_OFS_CTRL, 32'h1);
        wr(`IOE_OFS_WREG, 32'h01);
        mem_wr(12'ha2c, 8'h01);
        xfer(1'b1, `IOE_OFS_INSTR, 32'h242c);
        xfer(1'b1, `IOE_OFS_WREG, 32'h55);
        chk({31'h0, rerr}, 32'h1);
        wait_idle();
        rd_chk(`IOE_OFS_WREG, 32'h02);
        xfer(1'b0, 8'h24, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        xfer(1'b1, `IOE_OFS_EADDR, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // An unknown word writes no data or flags; it raises the illegal and, as offset 00h, the indexed status bits.
        wr(`IOE_OFS_STATUS, 32'h0);
        run(16'h0000);
        rd_chk(`IOE_OFS_STATUS, 32'h600);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_add();
        t_bits();
        t_modes();
        t_busy();
        end_of_test();
    end
    // The tests take a few hundred cycles; this limit leaves a wide margin.
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule

bind ioe_exec ioe_exec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_reg(prdata_reg),
    .pready_reg(pready_reg), .pslverr_reg(pslverr_reg), .exec_busy(exec_busy));
